// ### rtl/dts_top.v
// Debug assist unit: sense comparators, halt/trigger logic and trace stack
`timescale 1ns/1ns
`default_nettype none
`include "dts_defines.vh"
module dts_top (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// CPU state sampled every beat
	input wire [`DTS_UCODE_W-1:0] microcode_location,
	input wire [`DTS_VADDR_W-1:0] virtual_addr_bus_n,
	input wire [`DTS_BPD_W-1:0] backplane_data,
	// Comparator references
	input wire [`DTS_UCODE_W-1:0] cmp_one_ref,
	input wire [`DTS_UCODE_W-1:0] cmp_two_ref,
	input wire [`DTS_VADDR_W-1:0] cmp_three_ref,
	input wire [`DTS_BPD_W-1:0] cmp_four_ref,
	// Condition selection
	input wire [`DTS_MODE_W-1:0] halt_mode,
	input wire [`DTS_MODE_W-1:0] trig_mode,
	input wire capture_rearm,
	input wire halt_clear,
	// Local microprocessor access
	input wire local_wr,
	input wire [`DTS_LADDR_W-1:0] local_addr,
	input wire stack_rd_req,
	input wire [`DTS_STACK_AW-1:0] stack_rd_addr,
	// CPU controls
	output reg cpu_halt_request_n,
	output reg stack_trigger,
	// Stack status
	output reg [`DTS_STACK_AW-1:0] stack_wr_addr,
	output reg stack_frozen,
	output reg stack_busy,
	output reg capture_overrun,
	output reg tristate_hold,
	// Tristate readout bus
	output reg [`DTS_ENTRY_W-1:0] rd_bus_out,
	output reg rd_bus_oe_n
);
	// ****************************************
	// Functions
	// ****************************************
	function cond_fire;
		input [`DTS_MODE_W-1:0] mode;
		input m1;
		input m2;
		input m3;
		input m4;
		input sticky;
		begin
			case (mode)
				`DTS_COND_CMP1: cond_fire = m1;
				`DTS_COND_CMP2: cond_fire = m2;
				`DTS_COND_CMP3: cond_fire = m3;
				`DTS_COND_CMP4: cond_fire = m4;
				`DTS_COND_EA_IN_UC: cond_fire = m3 & m2;
				`DTS_COND_STICKY_1_2: cond_fire = sticky & m2;
				default: cond_fire = 1'b0;
			endcase
		end
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	reg m1_reg;
	reg m2_reg;
	reg m3_reg;
	reg m4_reg;
	reg sticky_reg;
	reg [`DTS_ENTRY_W-1:0] hold_reg;
	reg hold_valid_reg;
	reg [`DTS_STACK_AW-1:0] post_cnt_reg;
	reg post_run_reg;
	reg [`DTS_ENTRY_W-1:0] wdata_reg;
	reg wpulse_reg;
	reg [`DTS_ENTRY_W-1:0] stack_mem [0:`DTS_STACK_DEPTH-1];
	reg [`DTS_ENTRY_W-1:0] rd_data_reg;
	reg rd_valid_reg;
	wire sticky_now;
	wire halt_hit;
	wire trig_hit;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [`DTS_ENTRY_W-1:0] fifo_out_data;
	wire [`DTS_ENTRY_W-1:0] entry_now;
	wire post_done;

	// ****************************************
	// Comparators, first beat
	// ****************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			m1_reg <= 1'b0;
			m2_reg <= 1'b0;
			m3_reg <= 1'b0;
			m4_reg <= 1'b0;
			sticky_reg <= 1'b0;
		end else begin
			m1_reg <= (microcode_location == cmp_one_ref);
			m2_reg <= (microcode_location == cmp_two_ref);
			m3_reg <= (~virtual_addr_bus_n == cmp_three_ref);
			m4_reg <= (backplane_data == cmp_four_ref);
			if (m1_reg) begin
				sticky_reg <= 1'b1;
			end
		end
	end

	assign sticky_now = sticky_reg | m1_reg;
	assign halt_hit = cond_fire(halt_mode, m1_reg, m2_reg, m3_reg, m4_reg, sticky_now);
	assign trig_hit = cond_fire(trig_mode, m1_reg, m2_reg, m3_reg, m4_reg, sticky_now);

	// ****************************************
	// Halt and trigger, second beat
	// ****************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_halt_request_n <= 1'b1;
			stack_trigger <= 1'b0;
		end else begin
			if (halt_hit) begin
				cpu_halt_request_n <= 1'b0;
			end else if (halt_clear) begin
				cpu_halt_request_n <= 1'b1;
			end
			// A match held over several beats still gives one pulse
			stack_trigger <= trig_hit & ~stack_frozen & ~post_run_reg & ~stack_trigger;
		end
	end

	// ****************************************
	// Post-trigger capture window
	// ****************************************
	assign post_done = post_run_reg & (post_cnt_reg == `DTS_CNT_ZERO);

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			post_cnt_reg <= `DTS_CNT_ZERO;
			post_run_reg <= 1'b0;
			stack_frozen <= 1'b0;
		end else begin
			// Trigger and freeze win over a rearm in the same beat
			if (stack_trigger) begin
				post_run_reg <= 1'b1;
				post_cnt_reg <= `DTS_POST_TRIG;
			end else if (post_done) begin
				post_run_reg <= 1'b0;
				stack_frozen <= 1'b1;
			end else if (capture_rearm) begin
				post_run_reg <= 1'b0;
				stack_frozen <= 1'b0;
			end else if (post_run_reg && hold_valid_reg && fifo_in_ready) begin
				post_cnt_reg <= post_cnt_reg - `DTS_CNT_ONE;
			end
		end
	end

	// ****************************************
	// Capture into holding registers
	// ****************************************
	assign entry_now = {microcode_location, virtual_addr_bus_n, backplane_data};

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_reg <= {`DTS_ENTRY_W{1'b0}};
			hold_valid_reg <= 1'b0;
			capture_overrun <= 1'b0;
		end else begin
			if (capture_rearm) begin
				capture_overrun <= 1'b0;
			end
			if (hold_valid_reg && !fifo_in_ready) begin
				// Stalled: keep the held beat, the live beat is lost
				capture_overrun <= 1'b1;
			end else begin
				hold_reg <= entry_now;
				hold_valid_reg <= ~stack_frozen & ~post_done;
			end
		end
	end

	dts_fifo #(
		.WIDTH(`DTS_FIFO_W),
		.DEPTH(`DTS_FIFO_DEPTH),
		.AW(`DTS_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(hold_valid_reg),
		.in_ready(fifo_in_ready),
		.in_data(hold_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ****************************************
	// Stack write stage
	// ****************************************
	// Readout owns the single RAM port; writes wait in the FIFO
	assign fifo_out_ready = ~stack_rd_req & ~wpulse_reg;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wdata_reg <= {`DTS_ENTRY_W{1'b0}};
			wpulse_reg <= 1'b0;
			stack_wr_addr <= {`DTS_STACK_AW{1'b0}};
			stack_busy <= 1'b0;
		end else begin
			if (fifo_out_valid && fifo_out_ready) begin
				wdata_reg <= fifo_out_data;
			end
			wpulse_reg <= fifo_out_valid & fifo_out_ready;
			if (wpulse_reg) begin
				stack_wr_addr <= stack_wr_addr + `DTS_PTR_ONE;
			end
			stack_busy <= fifo_out_valid | wpulse_reg;
		end
	end

	// No reset: stack contents survive a reset
	always @(posedge clk) begin
		if (wpulse_reg) begin
			stack_mem[stack_wr_addr] <= wdata_reg;
		end
	end

	// ****************************************
	// Readout and tristate hold
	// ****************************************
	always @(posedge clk) begin
		if (stack_rd_req) begin
			rd_data_reg <= stack_mem[stack_rd_addr];
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tristate_hold <= 1'b1;
			rd_valid_reg <= 1'b0;
			rd_bus_out <= {`DTS_ENTRY_W{1'b0}};
			rd_bus_oe_n <= 1'b1;
		end else begin
			if (local_wr && (local_addr == `DTS_RELEASE_ADDR)) begin
				tristate_hold <= 1'b0;
			end
			rd_valid_reg <= stack_rd_req;
			if (rd_valid_reg) begin
				rd_bus_out <= rd_data_reg;
			end
			rd_bus_oe_n <= tristate_hold | ~rd_valid_reg;
		end
	end
endmodule
`default_nettype wire

// ### inc/dts_defines.vh
// Constants for the debug trigger and trace stack block
`ifndef DTS_DEFINES_VH
`define DTS_DEFINES_VH

// ****************************************
// Widths
// ****************************************
`define DTS_UCODE_W 14
`define DTS_VADDR_W 24
`define DTS_BPD_W 32
`define DTS_ENTRY_W 70
`define DTS_STACK_AW 10
`define DTS_STACK_DEPTH 1024
`define DTS_LADDR_W 16
`define DTS_MODE_W 3

// ****************************************
// Entry field layout
// ****************************************
`define DTS_ENT_BPD_LSB 0
`define DTS_ENT_VADDR_LSB 32
`define DTS_ENT_UCODE_LSB 56

// ****************************************
// Halt and trigger condition codes
// ****************************************
`define DTS_COND_NONE 3'h0
`define DTS_COND_CMP1 3'h1
`define DTS_COND_CMP2 3'h2
`define DTS_COND_CMP3 3'h3
`define DTS_COND_CMP4 3'h4
`define DTS_COND_EA_IN_UC 3'h5
`define DTS_COND_STICKY_1_2 3'h6

// ****************************************
// Fixed values
// ****************************************
`define DTS_RELEASE_ADDR 16'he01f
`define DTS_FIFO_W 70
`define DTS_FIFO_DEPTH 16
`define DTS_FIFO_AW 4
`define DTS_POST_TRIG 10'h0_200
`define DTS_PTR_ONE 10'h0_001
`define DTS_CNT_ONE 10'h0_001
`define DTS_CNT_ZERO 10'h0_000

`endif

// ### rtl/dts_fifo.v
// Synchronous flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dts_fifo #(
	parameter WIDTH = 70,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/dts_top_assertions.sv
// Port assertions for the debug assist unit
`timescale 1ns/1ns
`default_nettype none
`include "dts_defines.vh"
module dts_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Inputs
	input wire logic [13:0] microcode_location,
	input wire logic [23:0] virtual_addr_bus_n,
	input wire logic [13:0] cmp_one_ref,
	input wire logic [13:0] cmp_two_ref,
	input wire logic [23:0] cmp_three_ref,
	input wire logic [2:0] halt_mode,
	input wire logic local_wr,
	input wire logic [15:0] local_addr,
	input wire logic stack_rd_req,
	// Outputs
	input wire logic cpu_halt_request_n,
	input wire logic stack_trigger,
	input wire logic [9:0] stack_wr_addr,
	input wire logic tristate_hold,
	input wire logic rd_bus_oe_n
);
	wire m1 = microcode_location == cmp_one_ref;
	wire m2 = microcode_location == cmp_two_ref;
	wire m3 = ~virtual_addr_bus_n == cmp_three_ref;
	logic seen_m1;
	// First comparator seen since reset
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_m1 <= 1'b0;
		end else if (m1) begin
			seen_m1 <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_halt; halt_mode == 3'h1 && m1 |-> ##2 !cpu_halt_request_n; endproperty
	a_halt: assert property (p_halt) else $error("halt");
	property p_ea; halt_mode == 3'h5 && m2 && m3 |-> ##2 !cpu_halt_request_n; endproperty
	a_ea: assert property (p_ea) else $error("ea");
	property p_stk; halt_mode == 3'h6 && m2 && (seen_m1 || m1) |-> ##2 !cpu_halt_request_n; endproperty
	a_stk: assert property (p_stk) else $error("sticky");
	property p_pulse; stack_trigger |=> !stack_trigger; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_rel; local_wr && local_addr == `DTS_RELEASE_ADDR |=> !tristate_hold; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_float; tristate_hold |-> rd_bus_oe_n; endproperty
	a_float: assert property (p_float) else $error("float");
	property p_drive; stack_rd_req |-> ##2 (tristate_hold || !rd_bus_oe_n); endproperty
	a_drive: assert property (p_drive) else $error("drive");
	property p_step; stack_wr_addr != $past(stack_wr_addr)
		|-> stack_wr_addr == $past(stack_wr_addr) + `DTS_PTR_ONE; endproperty
	a_step: assert property (p_step) else $error("step");
	c_halt: cover property (!cpu_halt_request_n);
	c_trig: cover property (stack_trigger);
	c_wrap: cover property (stack_wr_addr == 10'h000 && $past(stack_wr_addr) == 10'h3ff);
endmodule
bind dts_top dts_chk u_chk (.clk, .arst_n, .microcode_location, .virtual_addr_bus_n, .cmp_one_ref,
	.cmp_two_ref, .cmp_three_ref, .halt_mode, .local_wr, .local_addr, .stack_rd_req, .cpu_halt_request_n,
	.stack_trigger, .stack_wr_addr, .tristate_hold, .rd_bus_oe_n);
`default_nettype wire

// ### bench/dts_cpu_model.sv
// CPU and backplane model driving the sampled buses
`timescale 1ns/1ns
`default_nettype none
module dts_cpu_model (
	// Forcing
	input wire logic clk,
	input wire logic f,
	input wire logic [13:0] u,
	input wire logic [23:0] v,
	input wire logic [31:0] b,
	// Buses
	output logic [13:0] uc,
	output logic [23:0] va_n,
	output logic [31:0] bd
);
	logic [13:0] beat_reg = 14'h0000;
	always @(negedge clk) beat_reg <= beat_reg + 14'h0001;
	assign uc = f ? u : beat_reg;
	assign va_n = ~(f ? v : {10'h000, beat_reg});
	assign bd = f ? b : {18'h0_0000, beat_reg};
endmodule
`default_nettype wire

// ### bench/dts_top_test.sv
// Self-checking bench for the debug assist unit
`timescale 1ns/1ns
`default_nettype none
module dts_top_test;
	logic clk = 1'b0, arst_n = 1'b0, fe = 1'b0, hc = 1'b0, rr = 1'b0, lw = 1'b0, rq = 1'b0;
	logic [13:0] uf = 14'h0000, uc;
	logic [23:0] vf = 24'h00_0000, va;
	logic [31:0] bf = 32'h0000_0000, bd;
	logic [2:0] hm = 3'h0, tm = 3'h0;
	logic [15:0] la = 16'h0000;
	logic [9:0] ra = 10'h000, wa, a;
	logic [69:0] rb, pat = {14'h1a5c, ~24'h12_3456, 32'hcafe_0123};
	logic hn, tr, fz, bs, ov, th, oe;
	int n_mismatch = 0, compares = 0, i;
	always #50 clk = ~clk;
	dts_cpu_model cpu (.clk, .f(fe), .u(uf), .v(vf), .b(bf), .uc(uc), .va_n(va), .bd(bd));
	dts_top DUT (.clk, .arst_n, .microcode_location(uc), .virtual_addr_bus_n(va), .backplane_data(bd),
		.cmp_one_ref(14'h3ff1), .cmp_two_ref(14'h3ff2), .cmp_three_ref(24'hff_0003), .cmp_four_ref(32'hffff_0004),
		.halt_mode(hm), .trig_mode(tm), .capture_rearm(rr), .halt_clear(hc), .local_wr(lw), .local_addr(la),
		.stack_rd_req(rq), .stack_rd_addr(ra), .cpu_halt_request_n(hn), .stack_trigger(tr), .stack_wr_addr(wa),
		.stack_frozen(fz), .stack_busy(bs), .capture_overrun(ov), .tristate_hold(th), .rd_bus_out(rb),
		.rd_bus_oe_n(oe));
	task automatic chk(string n, logic [70:0] s, e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic tmo;
		if (i >= 5000) begin
			chk("timeout", 0, 1);
			finish_test;
		end
	endtask
	// One matching beat, fire or not
	task automatic hit(logic [2:0] m, logic [13:0] u, logic [23:0] v, logic [31:0] b, logic f);
		hm = m;
		tm = m;
		rr = 1'b1;
		cyc(1);
		{rr, fe, uf, vf, bf} = {2'b01, u, v, b};
		cyc(1);
		fe = 1'b0;
		chk("early", {hn, tr}, 2'b10);
		cyc(1);
		chk("fire", {hn, tr}, {~f, f});
		cyc(1);
		chk("pulse", {hn, tr}, {~f, 1'b0});
		hc = 1'b1;
		cyc(1);
		hc = 1'b0;
	endtask
	task automatic rd(logic [9:0] x, logic o);
		ra = x;
		rq = 1'b1;
		cyc(1);
		rq = 1'b0;
		cyc(1);
		chk("read", {rb, oe}, {pat, o});
	endtask
	initial begin
		cyc(4);
		chk("reset", {hn, tr, wa, fz, th, oe}, {2'b10, 10'h000, 3'b011});
		arst_n = 1'b1;
		hit(3'h6, 14'h3ff2, 0, 0, 0);
		hit(3'h5, 0, 24'hff_0003, 0, 0);
		hit(3'h5, 14'h3ff2, 24'hff_0003, 0, 1);
		hit(3'h1, 14'h3ff1, 0, 0, 1);
		hit(3'h6, 14'h3ff2, 0, 0, 1);
		hit(3'h2, 14'h3ff2, 0, 0, 1);
		hit(3'h3, 0, 24'hff_0003, 0, 1);
		hit(3'h4, 0, 0, 32'hffff_0004, 1);
		{hm, tm} = 6'h00;
		for (i = 0; i < 5000 && !fz; i++) cyc(1);
		tmo;
		// FIFO drains after the freeze
		cyc(60);
		a = wa;
		cyc(40);
		chk("frozen", {wa, bs}, {a, 1'b0});
		{lw, la} = {1'b1, 16'he01e};
		cyc(1);
		chk("hold", th, 1);
		la = 16'he01f;
		cyc(1);
		lw = 1'b0;
		chk("rel", th, 0);
		{rr, fe, uf, vf, bf} = {2'b11, pat[69:56], ~pat[55:32], pat[31:0]};
		cyc(1);
		rr = 1'b0;
		cyc(40);
		a = wa - 10'h001;
		rd(a, 1'b0);
		fe = 1'b0;
		arst_n = 1'b0;
		cyc(4);
		arst_n = 1'b1;
		rd(a, 1'b1);
		rq = 1'b1;
		cyc(4);
		a = wa;
		cyc(40);
		chk("stall", {wa, ov}, {a, 1'b1});
		rq = 1'b0;
		for (i = 0; i < 5000 && wa != 10'h3ff; i++) cyc(1);
		tmo;
		for (i = 0; i < 5000 && wa == 10'h3ff; i++) cyc(1);
		tmo;
		chk("wrap", wa, 0);
		cyc(2);
		finish_test;
	end
endmodule
`default_nettype wire
